// *** pkg/irq_controller_consts.vh ***
// Register map, field positions, reset values and vector numbers of the interrupt controller
`ifndef IRQ_CONTROLLER_CONSTS_VH
`define IRQ_CONTROLLER_CONSTS_VH

// ========================================
// Block placement (word addresses)
`define IC_BASE_ADDR 24'h00F060
`define IC_ADDR_W 24

// ========================================
// Register word offsets
`define IC_OFF_PRIO0 4'h0
`define IC_OFF_PRIO1 4'h1
`define IC_OFF_PRIO2 4'h2
`define IC_OFF_PRIO3 4'h3
`define IC_OFF_PRIO4 4'h4
`define IC_OFF_VBA 4'h5
`define IC_OFF_FIM 4'h6
`define IC_OFF_FIVAL 4'h7
`define IC_OFF_FIVAH 4'h8

// ========================================
// Reset values
`define IC_RST_PRIO 16'h0000
`define IC_RST_VBA 16'h0000
`define IC_RST_FIM 16'h0000
`define IC_RST_FIVAL 16'h0000
`define IC_RST_FIVAH 16'h0000

// ========================================
// Priority field positions in priority register 1 (high bit, then low bit)
`define IC_POS_SER_TX_IDLE 9
`define IC_POS_SER_TX_EMPTY 7
`define IC_POS_SPI_TX_EMPTY 5
`define IC_POS_SPI_RX_FULL 3
`define IC_POS_SER_TX_IDLE_LO 8
`define IC_POS_SER_TX_EMPTY_LO 6
`define IC_POS_SPI_TX_EMPTY_LO 4
`define IC_POS_SPI_RX_FULL_LO 2

// ========================================
// Priority field codes and fixed software levels
`define IC_FIELD_OFF 2'h0
`define IC_LEVEL_SOFT_LOWEST 2'h0
`define IC_LEVEL_SOFT_0 2'h0
`define IC_LEVEL_NONE 3'h0

// ========================================
// Vector numbers of the sources
`define IC_VEC_SOFT_0 7'h02
`define IC_VEC_SER_TX_EMPTY 7'h20
`define IC_VEC_SER_TX_IDLE 7'h21
`define IC_VEC_SPI_RX_FULL 7'h22
`define IC_VEC_SPI_TX_EMPTY 7'h23
`define IC_VEC_SOFT_LOWEST 7'h3F

`endif

// *** core/level_encoder.v ***
// One source: priority field to active level encoding with pending gate
`timescale 1ns/1ns
`include "irq_controller_consts.vh"

module level_encoder (
    // Source
    input wire pending,
    input wire [1:0] field,
    // Result, active set means request active; level gives the level
    output wire active,
    output wire [1:0] level
);

    // Code 00 masks; 01..11 map to levels 0..2, level 3 unreachable
    assign active = pending && (field != `IC_FIELD_OFF);
    assign level = (field == `IC_FIELD_OFF) ? 2'h0 : field - 2'h1;

endmodule // level_encoder

// *** core/priority_interrupt_controller.v ***
// Interrupt controller: priority registers, vector base, fast vector and arbitration
//
// Notes on behaviour
// - The register block sits at word base 00F060, each register at its offset from there.
// - Five priority registers live at word offsets 0 through 4.
// - The vector base register sits at offset 5 and forms normal vector addresses.
// - Fast match sits at offset 6, fast vector low and high halves at offsets 7 and 8.
// - Serial transmitter idle level is bits 9 to 8 of priority register 1.
// - Serial transmitter empty level is bits 7 to 6 of the same register.
// - SPI transmitter empty level is bits 5 to 4 of that register.
// - SPI receiver full level is bits 3 to 2 of that register.
// - Field 00 masks, 01 is level 0, 10 is level 1, 11 is level 2; all fields reset to 00.
// - These peripheral requests never reach level 3; level 2 is their ceiling.
// - Software interrupts are always enabled at fixed levels with no field to program.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`include "irq_controller_consts.vh"

module priority_interrupt_controller (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Register port
    input wire [23:0] addr,
    input wire [15:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [15:0] rd_data,
    // Peripheral requests (same clock domain)
    input wire ser_tx_idle_req,
    input wire ser_tx_empty_req,
    input wire spi_tx_empty_req,
    input wire spi_rx_full_req,
    input wire soft_irq_0_req,
    input wire soft_irq_lowest_req,
    // To core
    output reg irq_valid,
    output reg [1:0] irq_level,
    output reg [6:0] irq_vector,
    output reg [20:0] irq_address
);

    // ========================================
    // Address decode
    function hit;
        input [23:0] a;
        input [3:0] off;
        begin
            hit = (a == (`IC_BASE_ADDR + {20'h00000, off}));
        end
    endfunction

    // ========================================
    // Registers
    reg [15:0] prio0_reg;
    reg [15:0] prio1_reg;
    reg [15:0] prio2_reg;
    reg [15:0] prio3_reg;
    reg [15:0] prio4_reg;
    reg [15:0] vba_reg;
    reg [15:0] fim_reg;
    reg [15:0] fival_reg;
    reg [15:0] fivah_reg;

    always @(posedge sys_clk) begin
        if (rst) begin
            prio0_reg <= `IC_RST_PRIO;
            prio1_reg <= `IC_RST_PRIO;
            prio2_reg <= `IC_RST_PRIO;
            prio3_reg <= `IC_RST_PRIO;
            prio4_reg <= `IC_RST_PRIO;
            vba_reg <= `IC_RST_VBA;
            fim_reg <= `IC_RST_FIM;
            fival_reg <= `IC_RST_FIVAL;
            fivah_reg <= `IC_RST_FIVAH;
        end else if (wr_en) begin
            if (hit(addr, `IC_OFF_PRIO0)) prio0_reg <= wr_data;
            if (hit(addr, `IC_OFF_PRIO1)) prio1_reg <= wr_data;
            if (hit(addr, `IC_OFF_PRIO2)) prio2_reg <= wr_data;
            if (hit(addr, `IC_OFF_PRIO3)) prio3_reg <= wr_data;
            if (hit(addr, `IC_OFF_PRIO4)) prio4_reg <= wr_data;
            if (hit(addr, `IC_OFF_VBA)) vba_reg <= wr_data;
            if (hit(addr, `IC_OFF_FIM)) fim_reg <= wr_data;
            if (hit(addr, `IC_OFF_FIVAL)) fival_reg <= wr_data;
            if (hit(addr, `IC_OFF_FIVAH)) fivah_reg <= wr_data;
        end
    end

    // ========================================
    // Read path, unmapped words read zero
    reg [15:0] rd_next;
    always @* begin
        rd_next = 16'h0000;
        if (hit(addr, `IC_OFF_PRIO0)) rd_next = prio0_reg;
        if (hit(addr, `IC_OFF_PRIO1)) rd_next = prio1_reg;
        if (hit(addr, `IC_OFF_PRIO2)) rd_next = prio2_reg;
        if (hit(addr, `IC_OFF_PRIO3)) rd_next = prio3_reg;
        if (hit(addr, `IC_OFF_PRIO4)) rd_next = prio4_reg;
        if (hit(addr, `IC_OFF_VBA)) rd_next = vba_reg;
        if (hit(addr, `IC_OFF_FIM)) rd_next = fim_reg;
        if (hit(addr, `IC_OFF_FIVAL)) rd_next = fival_reg;
        if (hit(addr, `IC_OFF_FIVAH)) rd_next = fivah_reg;
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            rd_data <= 16'h0000;
        end else if (rd_en) begin
            rd_data <= rd_next;
        end else begin
            rd_data <= 16'h0000;
        end
    end

    // ========================================
    // Per-source enable and level
    wire ser_idle_act;
    wire ser_empty_act;
    wire spi_tx_act;
    wire spi_rx_act;
    wire [1:0] ser_idle_lvl;
    wire [1:0] ser_empty_lvl;
    wire [1:0] spi_tx_lvl;
    wire [1:0] spi_rx_lvl;

    level_encoder u_ser_idle (
        .pending(ser_tx_idle_req),
        .field(prio1_reg[`IC_POS_SER_TX_IDLE:`IC_POS_SER_TX_IDLE_LO]),
        .active(ser_idle_act),
        .level(ser_idle_lvl)
    );
    level_encoder u_ser_empty (
        .pending(ser_tx_empty_req),
        .field(prio1_reg[`IC_POS_SER_TX_EMPTY:`IC_POS_SER_TX_EMPTY_LO]),
        .active(ser_empty_act),
        .level(ser_empty_lvl)
    );
    level_encoder u_spi_tx (
        .pending(spi_tx_empty_req),
        .field(prio1_reg[`IC_POS_SPI_TX_EMPTY:`IC_POS_SPI_TX_EMPTY_LO]),
        .active(spi_tx_act),
        .level(spi_tx_lvl)
    );
    level_encoder u_spi_rx (
        .pending(spi_rx_full_req),
        .field(prio1_reg[`IC_POS_SPI_RX_FULL:`IC_POS_SPI_RX_FULL_LO]),
        .active(spi_rx_act),
        .level(spi_rx_lvl)
    );

    // ========================================
    // Arbitration
    // Score = level plus one, zero when idle; strict greater-than keeps earlier source on ties
    function [2:0] score;
        input act;
        input [1:0] lvl;
        begin
            score = act ? ({1'b0, lvl} + 3'h1) : `IC_LEVEL_NONE;
        end
    endfunction

    reg [2:0] best_score;
    reg [1:0] best_level;
    reg [6:0] best_vector;
    always @* begin
        // Software source 0 first and lowest software source last in tie order, both always enabled
        best_score = `IC_LEVEL_NONE;
        best_level = 2'h0;
        best_vector = 7'h00;
        if (score(soft_irq_0_req, `IC_LEVEL_SOFT_0) > best_score) begin
            best_score = score(soft_irq_0_req, `IC_LEVEL_SOFT_0);
            best_level = `IC_LEVEL_SOFT_0;
            best_vector = `IC_VEC_SOFT_0;
        end
        if (score(ser_empty_act, ser_empty_lvl) > best_score) begin
            best_score = score(ser_empty_act, ser_empty_lvl);
            best_level = ser_empty_lvl;
            best_vector = `IC_VEC_SER_TX_EMPTY;
        end
        if (score(ser_idle_act, ser_idle_lvl) > best_score) begin
            best_score = score(ser_idle_act, ser_idle_lvl);
            best_level = ser_idle_lvl;
            best_vector = `IC_VEC_SER_TX_IDLE;
        end
        if (score(spi_rx_act, spi_rx_lvl) > best_score) begin
            best_score = score(spi_rx_act, spi_rx_lvl);
            best_level = spi_rx_lvl;
            best_vector = `IC_VEC_SPI_RX_FULL;
        end
        if (score(spi_tx_act, spi_tx_lvl) > best_score) begin
            best_score = score(spi_tx_act, spi_tx_lvl);
            best_level = spi_tx_lvl;
            best_vector = `IC_VEC_SPI_TX_EMPTY;
        end
        if (score(soft_irq_lowest_req, `IC_LEVEL_SOFT_LOWEST) > best_score) begin
            best_score = score(soft_irq_lowest_req, `IC_LEVEL_SOFT_LOWEST);
            best_level = `IC_LEVEL_SOFT_LOWEST;
            best_vector = `IC_VEC_SOFT_LOWEST;
        end
    end

    // ========================================
    // Vector address
    // Base fills the upper bits, vector number the low seven; fast path overrides
    wire fast_hit = (fim_reg[6:0] == best_vector);
    wire [20:0] normal_addr = {vba_reg[13:0], best_vector};
    wire [20:0] fast_addr = {fivah_reg[4:0], fival_reg};

    always @(posedge sys_clk) begin
        if (rst) begin
            irq_valid <= 1'b0;
            irq_level <= 2'h0;
            irq_vector <= 7'h00;
            irq_address <= 21'h000000;
        end else begin
            irq_valid <= (best_score != `IC_LEVEL_NONE);
            irq_level <= best_level;
            irq_vector <= best_vector;
            irq_address <= fast_hit ? fast_addr : normal_addr;
        end
    end

endmodule // priority_interrupt_controller

// *** test/irq_controller_monitor.sv ***
// Assertion checker for the interrupt controller ports
`timescale 1ns/1ns
module irq_controller_monitor (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Register port
    input wire [23:0] addr,
    input wire [15:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    input wire [15:0] rd_data,
    // Requests
    input wire ser_tx_idle_req,
    input wire ser_tx_empty_req,
    input wire spi_tx_empty_req,
    input wire spi_rx_full_req,
    input wire soft_irq_0_req,
    input wire soft_irq_lowest_req,
    // To core
    input wire irq_valid,
    input wire [1:0] irq_level,
    input wire [6:0] irq_vector,
    input wire [20:0] irq_address
);
    // ========================================
    // Shadow of the register file
    reg [15:0] sh [0:8];
    reg [15:0] exp_reg;
    integer i;
    wire hit = (addr >= 24'h00F060) && (addr <= 24'h00F068);
    wire any_req = ser_tx_idle_req | ser_tx_empty_req | spi_tx_empty_req | spi_rx_full_req
        | soft_irq_0_req | soft_irq_lowest_req;
    always @(posedge sys_clk) begin
        if (rst) begin
            for (i = 0; i < 9; i = i + 1) sh[i] <= 16'h0000;
            exp_reg <= 16'h0000;
        end else begin
            if (wr_en && hit) sh[addr[3:0]] <= wr_data;
            exp_reg <= (rd_en && hit) ? sh[addr[3:0]] : 16'h0000;
        end
    end
    // ========================================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_read_data: assert property (rd_data == exp_reg)
        else $error("read data differs from register");
    a_level_ceiling: assert property (irq_valid |-> irq_level != 2'h3)
        else $error("level three forwarded");
    a_quiet_idle: assert property (!any_req |=> !irq_valid)
        else $error("forward without request");
    a_soft_enabled: assert property (soft_irq_lowest_req |=> irq_valid)
        else $error("software request not forwarded");
    a_soft_first: assert property (soft_irq_0_req |=> irq_valid
        && (irq_level != 2'h0 || irq_vector == 7'h02)) else $error("tie order broken");
    a_vector_addr: assert property (irq_valid |-> irq_address ==
        (($past(sh[6]) & 16'h007F) == {9'h000, irq_vector} ? {$past(sh[8][4:0]), $past(sh[7])}
        : {$past(sh[5][13:0]), irq_vector})) else $error("vector address wrong");
    a_idle_top: assert property (ser_tx_idle_req && sh[1][9:8] == 2'h3
        |=> irq_valid && irq_level == 2'h2) else $error("idle level wrong");
    a_rx_top: assert property (spi_rx_full_req && sh[1][3:2] == 2'h3
        |=> irq_valid && irq_level == 2'h2) else $error("receive level wrong");
endmodule // irq_controller_monitor

bind priority_interrupt_controller irq_controller_monitor irq_controller_monitor_i (.sys_clk,
    .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .ser_tx_idle_req, .ser_tx_empty_req,
    .spi_tx_empty_req, .spi_rx_full_req, .soft_irq_0_req, .soft_irq_lowest_req, .irq_valid,
    .irq_level, .irq_vector, .irq_address);

// *** test/core_model.sv ***
// Core side model counting forwarded interrupts
`timescale 1ns/1ns
module core_model (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // From controller
    input wire irq_valid,
    // Count of cycles with a forwarded request
    output reg [15:0] taken_cnt
);
    always @(posedge sys_clk) begin
        if (rst) begin
            taken_cnt <= 16'h0000;
        end else if (irq_valid) begin
            taken_cnt <= taken_cnt + 16'h0001;
        end
    end
endmodule // core_model

// *** test/priority_interrupt_controller_tb.sv ***
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
module priority_interrupt_controller_tb;
    reg sys_clk = 1'b0;
    reg rst = 1'b1;
    reg [23:0] addr = 24'h000000;
    reg [15:0] wr_data = 16'h0000;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    reg [5:0] req = 6'h00;
    reg [31:0] seed = 32'h0000B508;
    reg [15:0] mem [0:8];
    wire [15:0] rd_data, taken_cnt;
    wire irq_valid;
    wire [1:0] irq_level;
    wire [6:0] irq_vector;
    wire [20:0] irq_address;
    integer error_cnt = 0, check_count = 0, cyc = 0, i, b, c;
    priority_interrupt_controller priority_interrupt_controller_i (.sys_clk(sys_clk), .rst(rst),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .soft_irq_0_req(req[0]), .ser_tx_empty_req(req[1]), .ser_tx_idle_req(req[2]),
        .spi_rx_full_req(req[3]), .spi_tx_empty_req(req[4]), .soft_irq_lowest_req(req[5]),
        .irq_valid(irq_valid), .irq_level(irq_level), .irq_vector(irq_vector),
        .irq_address(irq_address));
    core_model core_model_i (.sys_clk(sys_clk), .rst(rst), .irq_valid(irq_valid),
        .taken_cnt(taken_cnt));
    always #10 sys_clk = ~sys_clk;
    // ========================================
    // Helpers
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task check(input [31:0] seen, input [31:0] want);
        begin
            check_count = check_count + 1;
            if (seen !== want) begin
                error_cnt = error_cnt + 1;
                $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
            end
        end
    endtask
    task wr(input [23:0] a, input [15:0] d);
        begin
            addr <= a; wr_data <= d; wr_en <= 1'b1;
            @(posedge sys_clk);
            wr_en <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task rd(input [23:0] a, input [15:0] e);
        begin
            addr <= a; rd_en <= 1'b1;
            @(posedge sys_clk);
            rd_en <= 1'b0;
            #1 check(rd_data, e);
            @(posedge sys_clk);
        end
    endtask
    // Request set, one cycle for the registered answer
    task see(input [5:0] v, input val, input [1:0] lvl, input [6:0] vec);
        begin
            req <= v;
            @(posedge sys_clk);
            #1 check(val ? {irq_valid, irq_level, irq_vector} : irq_valid,
                val ? {val, lvl, vec} : 1'b0);
            @(posedge sys_clk);
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", check_count, error_cnt);
            if (error_cnt == 0 && check_count > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    // Generous ceiling; the sequence needs about 150 cycles
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc > 3000) begin
            error_cnt = error_cnt + 1;
            end_of_test;
        end
    end
    // ========================================
    // Sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        for (i = 0; i < 9; i = i + 1) rd(24'h00F060 + i, 16'h0000);
        for (i = 0; i < 9; i = i + 1) begin
            seed = xs(seed);
            mem[i] = seed[15:0];
            wr(24'h00F060 + i, mem[i]);
        end
        wr(24'h00F069, seed[31:16]);
        for (i = 0; i < 9; i = i + 1) rd(24'h00F060 + i, mem[i]);
        rd(24'h00F069, 16'h0000);
        rd(24'h00F05F, 16'h0000);
        $display("register map test done");
        // Every code of every field, one source at a time
        for (b = 1; b < 5; b = b + 1) begin
            for (c = 0; c < 4; c = c + 1) begin
                wr(24'h00F061, (16'h0001 * c) << ((b < 3) ? 4 + 2 * b : 2 * b - 4));
                see(6'h01 << b, c != 0, c - 1, 7'h1F + b);
            end
        end
        $display("field test done");
        wr(24'h00F061, 16'h0304);
        see(6'h0D, 1'b1, 2'h2, 7'h21);
        wr(24'h00F061, 16'h0100);
        see(6'h05, 1'b1, 2'h0, 7'h02);
        see(6'h20, 1'b1, 2'h0, 7'h3F);
        $display("arbitration test done");
        wr(24'h00F061, 16'h0300);
        wr(24'h00F066, 16'h0021);
        see(6'h04, 1'b1, 2'h2, 7'h21);
        check(irq_address, {mem[8][4:0], mem[7]});
        wr(24'h00F066, 16'h0000);
        see(6'h04, 1'b1, 2'h2, 7'h21);
        check(irq_address, {mem[5][13:0], 7'h21});
        see(6'h00, 1'b0, 2'h0, 7'h00);
        check(taken_cnt != 16'h0000, 1);
        $display("fast vector test done");
        end_of_test;
    end
endmodule // priority_interrupt_controller_tb
